/* logic/pfm_pin_mux.v */
`include "pfm_defines.vh"
// Notes on behaviour
// - selected function alone connects to the pin
// - analog path enabled only on analog code
// - direction bit counts only under gpio
// - both select registers reset to zero
// - low register holds pins 0..15 fields
// - pins 0,1 uart0 or timer3 matches
// - pins 2..5 i2c/spi or timer0 functions
// - pins 6..8 spi, uart1 or timer functions
// - pins 9..12 uart, timer2/timer1 or analog
// - high register bits 1:0 steer pin 16
// - codes 00 gpio, then alternates one..three
module pfm_pin_mux (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire        ce,                                // clock enable, low freezes all state
  // ****************************************************************
  // axi4-lite register port
  // ****************************************************************
  input  wire [31:0] awaddr,
  input  wire        awvalid,
  output wire        awready,
  input  wire [31:0] wdata,
  input  wire [3:0]  wstrb,
  input  wire        wvalid,
  output wire        wready,
  output wire [1:0]  bresp,
  output wire        bvalid,
  input  wire        bready,
  input  wire [31:0] araddr,
  input  wire        arvalid,
  output wire        arready,
  output wire [31:0] rdata,
  output wire [1:0]  rresp,
  output wire        rvalid,
  input  wire        rready,
  // ****************************************************************
  // pads and gpio
  // ****************************************************************
  input  wire [16:0] pad_in,                            // pad levels
  output wire [16:0] pad_out,                           // pad output data
  output wire [16:0] pad_oe,                            // pad driver enables
  input  wire [16:0] gpio_out,                          // gpio output data
  input  wire [16:0] port_direction_register,           // gpio direction bits
  output wire [16:0] gpio_in,                           // pad levels routed to gpio
  // ****************************************************************
  // peripheral side
  // ****************************************************************
  input  wire        first_uart_transmit,
  output wire        first_uart_receive,
  input  wire        timer3_match1_out,
  input  wire        timer3_match2_out,
  input  wire        first_i2c_clock_oe,                // open drain, pulls low
  output wire        first_i2c_clock,
  input  wire        first_i2c_data_oe,                 // open drain, pulls low
  output wire        first_i2c_data,
  output wire        timer0_capture0_in,
  input  wire        timer0_match0_out,
  input  wire        first_spi_clock_out,
  input  wire        first_spi_clock_oe,
  output wire        first_spi_clock,
  input  wire        first_spi_master_in_out,
  input  wire        first_spi_master_in_oe,
  output wire        first_spi_master_in,
  input  wire        first_spi_master_out_out,
  input  wire        first_spi_master_out_oe,
  output wire        first_spi_master_out,
  output wire        timer0_capture1_in,
  input  wire        timer0_match1_out,
  output wire        timer0_capture2_in,
  output wire        first_spi_slave_select,
  input  wire        timer2_match0_out,
  input  wire        second_uart_transmit,
  input  wire        timer2_match1_out,
  output wire        second_uart_receive,
  input  wire        timer2_match2_out,
  input  wire        second_uart_request_to_send,
  output wire        timer1_capture0_in,
  output wire        analog_channel3_en,
  output wire        second_uart_clear_to_send,
  output wire        timer1_capture1_in,
  output wire        analog_channel4_en,
  output wire        second_uart_set_ready,
  input  wire        timer1_match0_out,
  output wire        analog_channel5_en,
  input  wire        timer1_match1_out,
  input  wire        second_uart_terminal_ready,
  output wire        external_interrupt1,
  input  wire        second_sync_serial_clock_out,
  input  wire        second_sync_serial_clock_oe,
  output wire        second_sync_serial_clock,
  output wire        second_uart_carrier_detect,
  output wire        external_interrupt2,
  output wire        second_uart_ring_indicator,
  output wire        external_interrupt0,
  input  wire        timer0_match2_out
);

  // ****************************************************************
  // declarations
  // ****************************************************************
  reg  [31:0] pin_function_select_low_q;                // fields for pins 0..15
  reg  [31:0] pin_function_select_low_d;                // next low value
  reg  [1:0]  pin_function_select_high_q;               // field for pin 16
  reg  [1:0]  pin_function_select_high_d;               // next high value
  wire        wr_en;                                    // write commit pulse
  wire [31:0] wr_addr;                                  // write byte address
  wire [31:0] wr_data;                                  // write data
  wire [3:0]  wr_strb;                                  // write byte strobes
  wire        wr_ok;                                    // write address mapped
  wire [31:0] rd_addr;                                  // read byte address
  reg  [31:0] rd_data;                                  // read data
  reg         rd_ok;                                    // read address mapped
  wire [33:0] sel_all;                                  // all 17 fields packed
  wire [67:0] alt_out;                                  // alternate output data
  wire [67:0] alt_oe;                                   // alternate directions
  wire [67:0] alt_in;                                   // pad level per alternate
  wire [67:0] alt_ok;                                   // non-reserved codes
  wire [67:0] alt_ana;                                  // analog codes
  wire [16:0] analog_en;                                // analog path per pin
  integer     b;                                        // byte lane index

  // ****************************************************************
  // bus slave
  // ****************************************************************
  pfm_axil_slave u_bus (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ce      (ce),
    .awaddr  (awaddr),
    .awvalid (awvalid),
    .awready (awready),
    .wdata   (wdata),
    .wstrb   (wstrb),
    .wvalid  (wvalid),
    .wready  (wready),
    .bresp   (bresp),
    .bvalid  (bvalid),
    .bready  (bready),
    .araddr  (araddr),
    .arvalid (arvalid),
    .arready (arready),
    .rdata   (rdata),
    .rresp   (rresp),
    .rvalid  (rvalid),
    .rready  (rready),
    .wr_en   (wr_en),
    .wr_addr (wr_addr),
    .wr_data (wr_data),
    .wr_strb (wr_strb),
    .wr_ok   (wr_ok),
    .rd_addr (rd_addr),
    .rd_data (rd_data),
    .rd_ok   (rd_ok)
  );

  // unmapped addresses answer with an error
  assign wr_ok = (wr_addr == `PFM_SEL_LOW_ADDR) || (wr_addr == `PFM_SEL_HIGH_ADDR);

  // ****************************************************************
  // select registers
  // ****************************************************************
  // byte-lane merge of a write into the stored fields
  always @* begin
    pin_function_select_low_d  = pin_function_select_low_q;
    pin_function_select_high_d = pin_function_select_high_q;
    if (wr_en && wr_addr == `PFM_SEL_LOW_ADDR) begin
      for (b = 0; b < 4; b = b + 1) begin
        if (wr_strb[b]) begin
          pin_function_select_low_d[8*b +: 8] = wr_data[8*b +: 8];
        end
      end
    end
    if (wr_en && wr_addr == `PFM_SEL_HIGH_ADDR && wr_strb[0]) begin
      pin_function_select_high_d = wr_data[`PFM_SEL_HIGH_W-1:0];
    end
  end

  // stored fields steer the pads from the next cycle on
  always @(posedge aclk) begin
    if (!aresetn) begin
      pin_function_select_low_q  <= `PFM_SEL_LOW_RST;
      pin_function_select_high_q <= `PFM_SEL_HIGH_RST;
    end else if (ce) begin
      pin_function_select_low_q  <= pin_function_select_low_d;
      pin_function_select_high_q <= pin_function_select_high_d;
    end
  end

  // readback of stored fields, unimplemented bits read zero
  always @* begin
    rd_data = 32'h00000000;
    rd_ok   = 1'b1;
    case (rd_addr)
      `PFM_SEL_LOW_ADDR: begin
        rd_data = pin_function_select_low_q;
      end
      `PFM_SEL_HIGH_ADDR: begin
        rd_data[`PFM_SEL_HIGH_W-1:0] = pin_function_select_high_q;
      end
      default: begin
        rd_ok = 1'b0;
      end
    endcase
  end

  // ****************************************************************
  // per-pin function tables, nibble = {alt3, alt2, alt1, gpio}
  // ****************************************************************
  // low register fields 2n+1:2n
  assign sel_all = {pin_function_select_high_q, pin_function_select_low_q};
  assign alt_ok  = `PFM_VALID_MASK;
  assign alt_ana = `PFM_ANALOG_MASK;

  assign alt_out[7:0]   = {1'b0, timer3_match2_out, 1'b0, 1'b0, 1'b0, timer3_match1_out, first_uart_transmit, 1'b0};
  assign alt_oe[7:0]    = {1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
  assign alt_out[15:8]  = {1'b0, timer0_match0_out, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0};
  assign alt_oe[15:8]   = {1'b0, 1'b1, first_i2c_data_oe, 1'b0, 1'b0, 1'b0, first_i2c_clock_oe, 1'b0};
  assign alt_out[23:16] = {1'b0, timer0_match1_out, first_spi_master_in_out, 1'b0,
                           1'b0, 1'b0, first_spi_clock_out, 1'b0};
  assign alt_oe[23:16]  = {1'b0, 1'b1, first_spi_master_in_oe, 1'b0, 1'b0, 1'b0, first_spi_clock_oe, 1'b0};
  assign alt_out[35:24] = {1'b0, timer2_match1_out, second_uart_transmit, 1'b0,
                           1'b0, timer2_match0_out, 1'b0, 1'b0, 1'b0, 1'b0, first_spi_master_out_out, 1'b0};
  assign alt_oe[35:24]  = {1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0,
                           1'b0, 1'b0, first_spi_master_out_oe, 1'b0};
  assign alt_out[51:36] = {1'b0, timer1_match0_out, 1'b0, 1'b0, 4'h0,
                           1'b0, 1'b0, second_uart_request_to_send, 1'b0, 1'b0, timer2_match2_out, 1'b0, 1'b0};
  assign alt_oe[51:36]  = {1'b0, 1'b1, 1'b0, 1'b0, 4'h0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0};
  assign alt_out[63:52] = {4'h0, 1'b0, second_sync_serial_clock_out, 1'b0, 1'b0,
                           second_uart_terminal_ready, timer1_match1_out, 1'b0, 1'b0};
  assign alt_oe[63:52]  = {4'h0, 1'b0, second_sync_serial_clock_oe, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0};
  assign alt_out[67:64] = {1'b0, timer0_match2_out, 1'b0, 1'b0};
  assign alt_oe[67:64]  = {1'b0, 1'b1, 1'b0, 1'b0};

  // inputs reach each peripheral only through its own selected pin
  assign first_uart_receive         = alt_in[5];
  assign first_i2c_clock            = alt_in[9];
  assign timer0_capture0_in         = alt_in[10];
  assign first_i2c_data             = alt_in[13];
  assign first_spi_clock            = alt_in[17];
  assign timer0_capture1_in         = alt_in[18];
  assign first_spi_master_in        = alt_in[21];
  assign first_spi_master_out       = alt_in[25];
  assign timer0_capture2_in         = alt_in[26];
  assign first_spi_slave_select     = alt_in[29];
  assign second_uart_receive        = alt_in[37];
  assign timer1_capture0_in         = alt_in[42];
  assign second_uart_clear_to_send  = alt_in[45];
  assign timer1_capture1_in         = alt_in[46];
  assign second_uart_set_ready      = alt_in[49];
  assign external_interrupt1        = alt_in[57];
  assign second_sync_serial_clock   = alt_in[58];
  assign second_uart_carrier_detect = alt_in[59];
  assign external_interrupt2        = alt_in[61];
  assign second_uart_ring_indicator = alt_in[63];
  assign external_interrupt0        = alt_in[65];
  assign analog_channel3_en         = analog_en[10];
  assign analog_channel4_en         = analog_en[11];
  assign analog_channel5_en         = analog_en[12];

  // ****************************************************************
  // pin multiplexers
  // ****************************************************************
  genvar p;
  generate
    for (p = 0; p < `PFM_PIN_CNT; p = p + 1) begin : g_pin
      pfm_pin_cell u_cell (
        .sel       (sel_all[2*p +: 2]),
        .gpio_out  (gpio_out[p]),
        .gpio_dir  (port_direction_register[p]),
        .f_out     (alt_out[4*p +: 4]),
        .f_oe      (alt_oe[4*p +: 4]),
        .f_ok      (alt_ok[4*p +: 4]),
        .f_ana     (alt_ana[4*p +: 4]),
        .pad_in    (pad_in[p]),
        .pad_out   (pad_out[p]),
        .pad_oe    (pad_oe[p]),
        .gpio_in   (gpio_in[p]),
        .f_in      (alt_in[4*p +: 4]),
        .analog_en (analog_en[p])
      );
    end
  endgenerate

endmodule

/* logic/pfm_defines.vh */
`ifndef PFM_DEFINES_VH
`define PFM_DEFINES_VH

// ****************************************************************
// register map
// ****************************************************************
// byte addresses of the two select registers
`define PFM_SEL_LOW_ADDR   32'hE002C000
`define PFM_SEL_HIGH_ADDR  32'hE002C004
// reset values, every pin starts as general-purpose i/o
`define PFM_SEL_LOW_RST    32'h00000000
`define PFM_SEL_HIGH_RST   2'h0
// implemented width of the high register (pin 16 field only)
`define PFM_SEL_HIGH_W     2

// ****************************************************************
// field layout and function codes
// ****************************************************************
`define PFM_FIELD_W        2
`define PFM_PIN_CNT        17
`define PFM_FUNC_GPIO      2'h0
`define PFM_FUNC_ALT1      2'h1
`define PFM_FUNC_ALT2      2'h2
`define PFM_FUNC_ALT3      2'h3
// one nibble per pin, bit k set when code k is not reserved
`define PFM_VALID_MASK     68'h7BFDFFF7777777777
// one nibble per pin, bit k set when code k is an analog input
`define PFM_ANALOG_MASK    68'h00008880000000000

// ****************************************************************
// bus answers
// ****************************************************************
`define PFM_RESP_OKAY      2'h0
`define PFM_RESP_SLVERR    2'h2

`endif

/* logic/pfm_pin_cell.v */
// ****************************************************************
// one pin: steers gpio or one alternate onto the pad
// ****************************************************************
`include "pfm_defines.vh"
module pfm_pin_cell (
  input  wire [1:0] sel,        // function code from the select field
  input  wire       gpio_out,   // gpio output data
  input  wire       gpio_dir,   // gpio direction bit, 1 = output
  input  wire [3:0] f_out,      // alternate output data per code
  input  wire [3:0] f_oe,       // alternate automatic direction per code
  input  wire [3:0] f_ok,       // code is not reserved
  input  wire [3:0] f_ana,      // code is an analog input
  input  wire       pad_in,     // level seen on the pad
  output reg        pad_out,    // level driven onto the pad
  output reg        pad_oe,     // pad driver enable
  output reg        gpio_in,    // pad level seen by gpio
  output reg  [3:0] f_in,       // pad level seen by each alternate
  output reg        analog_en   // analog interface path enabled
);

  integer k;                    // code index

  // ****************************************************************
  // exclusive routing
  // ****************************************************************
  // only the selected function sees or drives the pad
  always @* begin
    pad_out   = 1'b0;
    pad_oe    = 1'b0;
    gpio_in   = 1'b0;
    f_in      = 4'h0;
    analog_en = 1'b0;
    if (sel == `PFM_FUNC_GPIO) begin
      pad_out = gpio_out;
      pad_oe  = gpio_dir;
      gpio_in = pad_in;
    end else if (!f_ok[sel]) begin
      pad_oe = 1'b0;
    end else if (f_ana[sel]) begin
      analog_en = 1'b1;
    end else begin
      pad_out = f_out[sel];
      pad_oe  = f_oe[sel];
      for (k = 1; k < 4; k = k + 1) begin
        if (sel == k[1:0]) begin
          f_in[k] = pad_in;
        end
      end
    end
  end

endmodule

/* logic/pfm_axil_slave.v */
// ****************************************************************
// axi4-lite slave front end, one write and one read in flight
// ****************************************************************
`include "pfm_defines.vh"
module pfm_axil_slave (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire        ce,
  input  wire [31:0] awaddr,
  input  wire        awvalid,
  output wire        awready,
  input  wire [31:0] wdata,
  input  wire [3:0]  wstrb,
  input  wire        wvalid,
  output wire        wready,
  output reg  [1:0]  bresp,
  output reg         bvalid,
  input  wire        bready,
  input  wire [31:0] araddr,
  input  wire        arvalid,
  output wire        arready,
  output reg  [31:0] rdata,
  output reg  [1:0]  rresp,
  output reg         rvalid,
  input  wire        rready,
  output wire        wr_en,
  output wire [31:0] wr_addr,
  output wire [31:0] wr_data,
  output wire [3:0]  wr_strb,
  input  wire        wr_ok,
  output wire [31:0] rd_addr,
  input  wire [31:0] rd_data,
  input  wire        rd_ok
);

  reg        aw_full_q;         // write address held
  reg        w_full_q;          // write data held
  reg [31:0] aw_addr_q;         // held write address
  reg [31:0] w_data_q;          // held write data
  reg [3:0]  w_strb_q;          // held byte strobes

  // accept each write channel while its holder is empty and no write answer is pending
  assign awready = ce && !aw_full_q && !bvalid;
  assign wready  = ce && !w_full_q && !bvalid;
  // a read is taken only when no read answer is pending
  assign arready = ce && !rvalid;
  // the write commits once both halves are in
  assign wr_en   = ce && aw_full_q && w_full_q && !bvalid;
  assign wr_addr = aw_addr_q;
  assign wr_data = w_data_q;
  assign wr_strb = w_strb_q;
  assign rd_addr = araddr;

  // ****************************************************************
  // channel state
  // ****************************************************************
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_q <= 1'b0;
      w_full_q  <= 1'b0;
      aw_addr_q <= 32'h00000000;
      w_data_q  <= 32'h00000000;
      w_strb_q  <= 4'h0;
      bvalid    <= 1'b0;
      bresp     <= `PFM_RESP_OKAY;
      rvalid    <= 1'b0;
      rresp     <= `PFM_RESP_OKAY;
      rdata     <= 32'h00000000;
    end else if (ce) begin
      // capture address
      if (awvalid && awready) begin
        aw_full_q <= 1'b1;
        aw_addr_q <= awaddr;
      end
      // capture data
      if (wvalid && wready) begin
        w_full_q <= 1'b1;
        w_data_q <= wdata;
        w_strb_q <= wstrb;
      end
      // commit and answer
      if (wr_en) begin
        aw_full_q <= 1'b0;
        w_full_q  <= 1'b0;
        bvalid    <= 1'b1;
        bresp     <= wr_ok ? `PFM_RESP_OKAY : `PFM_RESP_SLVERR;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
      // read answer one cycle after the address
      if (arvalid && arready) begin
        rvalid <= 1'b1;
        rdata  <= rd_ok ? rd_data : 32'h00000000;
        rresp  <= rd_ok ? `PFM_RESP_OKAY : `PFM_RESP_SLVERR;
      end else if (rvalid && rready) begin
        rvalid <= 1'b0;
      end
    end
  end

endmodule

/* testbench/pfm_pin_mux_sva.sv */
`include "pfm_defines.vh"
// ****************************************************************
// port checker for the pin mux
// ****************************************************************
module pfm_pin_mux_sva (
  input logic        aclk,
  input logic        aresetn,
  input logic [31:0] awaddr,
  input logic        awvalid,
  input logic        awready,
  input logic        wvalid,
  input logic        wready,
  input logic [1:0]  bresp,
  input logic        bvalid,
  input logic        bready,
  input logic        arvalid,
  input logic        arready,
  input logic [31:0] rdata,
  input logic        rvalid,
  input logic        rready,
  input logic [16:0] pad_in,
  input logic [16:0] pad_oe,
  input logic [16:0] gpio_in,
  input logic [16:0] port_direction_register,
  input logic        first_uart_receive,
  input logic        timer1_capture0_in,
  input logic        analog_channel3_en
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  chk_b_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write answer dropped early");
  chk_r_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read answer dropped early");
  chk_rd_lat: assert property (arvalid && arready |=> rvalid)
    else $error("read answer late");
  chk_wr_resp: assert property (awvalid && awready && wvalid && wready |-> ##2 bvalid &&
    bresp == (($past(awaddr, 2) & 32'hFFFFFFFB) == `PFM_SEL_LOW_ADDR ? 2'h0 : 2'h2)) else $error("bad write answer");
  chk_aw_block: assert property (bvalid |-> !awready && !wready)
    else $error("write taken during answer");
  chk_gpio_dir: assert property (gpio_in[0] |-> pad_in[0] && pad_oe[0] == port_direction_register[0])
    else $error("gpio direction not applied");
  chk_rx_excl: assert property (first_uart_receive |-> pad_in[1] && !gpio_in[1] && !pad_oe[1])
    else $error("pin 1 not exclusive");
  chk_analog_off: assert property (analog_channel3_en |-> !pad_oe[10] && !timer1_capture0_in && !gpio_in[10])
    else $error("digital path on analog pin");
endmodule

/* testbench/pfm_pad_model.sv */
// ****************************************************************
// pads and far side: undriven pads float, no pull
// ****************************************************************
module pfm_pad_model (
  input  logic        aclk,
  input  logic [16:0] pad_out,
  input  logic [16:0] pad_oe,
  output logic [16:0] pad_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [16:0] ext_q = 17'h0A5A5;  // outside level on released pads
  // no pull on these pads, so a floating pad keeps changing
  always @(posedge aclk) ext_q <= ~ext_q;
  // pad follows its one enabled driver
  assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_q);
endmodule

/* testbench/pfm_pin_mux_tb.sv */
`include "pfm_defines.vh"
module pfm_pin_mux_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] LO = `PFM_SEL_LOW_ADDR;
  localparam logic [31:0] HI = `PFM_SEL_HIGH_ADDR;
  logic aclk = 1'h0, aresetn = 1'h0, ce = 1'h1, awvalid = 1'h0, wvalid = 1'h0;
  logic bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0;
  logic [3:0]  wstrb = 4'h0;
  logic [16:0] gpio_out = 17'h1F0F0, port_direction_register = 17'h10FF0;
  logic [23:0] per_q = 24'hAAAAAA;  // peripheral drive levels
  int          n_mismatch = 0;
  int          check_count = 0;
  wire awready, wready, bvalid, arready, rvalid;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [16:0] pad_in, pad_out, pad_oe, gpio_in;
  wire first_uart_transmit, timer3_match1_out, timer3_match2_out, first_i2c_clock_oe, first_i2c_data_oe,
    timer0_match0_out, first_spi_clock_out, first_spi_clock_oe, first_spi_master_in_out, first_spi_master_in_oe,
    first_spi_master_out_out, first_spi_master_out_oe, timer0_match1_out, timer2_match0_out, second_uart_transmit,
    timer2_match1_out, timer2_match2_out, second_uart_request_to_send, timer1_match0_out, timer1_match1_out,
    second_uart_terminal_ready, second_sync_serial_clock_out, second_sync_serial_clock_oe, timer0_match2_out;
  wire first_uart_receive, first_i2c_clock, first_i2c_data, timer0_capture0_in, first_spi_clock, first_spi_master_in,
    first_spi_master_out, timer0_capture1_in, timer0_capture2_in, first_spi_slave_select, second_uart_receive,
    timer1_capture0_in, analog_channel3_en, second_uart_clear_to_send, timer1_capture1_in, analog_channel4_en,
    second_uart_set_ready, analog_channel5_en, external_interrupt1, second_sync_serial_clock,
    second_uart_carrier_detect, external_interrupt2, second_uart_ring_indicator, external_interrupt0;
  assign {first_uart_transmit, timer3_match1_out, timer3_match2_out, first_i2c_clock_oe, first_i2c_data_oe,
    timer0_match0_out, first_spi_clock_out, first_spi_clock_oe, first_spi_master_in_out, first_spi_master_in_oe,
    first_spi_master_out_out, first_spi_master_out_oe, timer0_match1_out, timer2_match0_out, second_uart_transmit,
    timer2_match1_out, timer2_match2_out, second_uart_request_to_send, timer1_match0_out, timer1_match1_out,
    second_uart_terminal_ready, second_sync_serial_clock_out, second_sync_serial_clock_oe, timer0_match2_out} = per_q;
  pfm_pin_mux   i_pfm_pin_mux (.*);
  pfm_pad_model i_pfm_pad_model (.*);
  initial forever #12.5 aclk = ~aclk;
  // ****************************************************************
  // checking and bus tasks
  // ****************************************************************
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task close_out;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task lost;
    n_mismatch++;
    close_out();
  endtask
  // write one word
  task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    for (n = 0; n < 64; n++) begin
      @(posedge aclk);
      if (awvalid && awready === 1'h1) awvalid <= 1'h0;
      if (wvalid && wready === 1'h1) wvalid <= 1'h0;
      if (bvalid === 1'h1) break;
    end
    bready <= 1'h0;
    if (n == 64) lost();
    chk("bresp", bresp, er);
    #1;
  endtask
  // read one word
  task automatic rd(input logic [31:0] a, input logic [31:0] ed, input logic [1:0] er);
    int n;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    for (n = 0; n < 64; n++) begin
      @(posedge aclk);
      if (arvalid && arready === 1'h1) arvalid <= 1'h0;
      if (rvalid === 1'h1) break;
    end
    rready <= 1'h0;
    if (n == 64) lost();
    chk("rdata", rdata, ed);
    chk("rresp", rresp, er);
    #1;
  endtask
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'h1;
    rd(LO, 32'h0, 2'h0);
    rd(HI, 32'h0, 2'h0);
    chk("pad_oe", pad_oe, port_direction_register);
    chk("pad_out", pad_out, gpio_out);
    chk("gpio_in", gpio_in, pad_in);
    $display("reset test done");
    wr(LO, 32'h55555555, 2'h0);
    rd(LO, 32'h55555555, 2'h0);
    chk("oe_low", pad_oe[3:0], 4'h9);
    chk("uart_tx", pad_out[0], 1'h1);
    chk("uart_rx", first_uart_receive, pad_in[1]);
    chk("gpio_off", gpio_in[15:0], 16'h0);
    chk("oe_16", pad_oe[16], port_direction_register[16]);
    chk("out_p8", pad_out[8], 1'h1);
    chk("alt1_in", {external_interrupt2, external_interrupt1, second_uart_set_ready, second_uart_clear_to_send,
      second_uart_receive, first_spi_slave_select, first_spi_master_out, first_spi_master_in, first_spi_clock,
      first_i2c_data, first_i2c_clock}, {pad_in[15:14], pad_in[12:11], pad_in[9], pad_in[7:2]});
    $display("first alternate test done");
    wr(LO, 32'hAAAAAAAA, 2'h0);
    chk("out_low", pad_out[1:0], 2'h2);
    chk("oe_low", pad_oe[3:0], 4'hB);
    chk("rx_off", first_uart_receive, 1'h0);
    chk("cap0", timer0_capture0_in, pad_in[2]);
    chk("oe_hi", pad_oe[15:6], 10'h1CE);
    chk("alt2_in", {second_sync_serial_clock, timer1_capture1_in, timer1_capture0_in, timer0_capture2_in,
      timer0_capture1_in}, {pad_in[14], pad_in[11:10], pad_in[6], pad_in[4]});
    $display("second alternate test done");
    wr(LO, 32'hFFFFFFFF, 2'h0);
    rd(LO, 32'hFFFFFFFF, 2'h0);
    chk("oe_rsv", pad_oe[1:0], 2'h0);
    chk("in_rsv", gpio_in[1:0], 2'h0);
    chk("analog", {analog_channel5_en, analog_channel4_en, analog_channel3_en}, 3'h7);
    chk("oe_ana", pad_oe[12:10], 3'h0);
    chk("dcd", second_uart_carrier_detect, pad_in[14]);
    chk("dtr_ri", {pad_out[13], second_uart_ring_indicator}, {1'h1, pad_in[15]});
    $display("third alternate test done");
    wr(HI, 32'hFFFFFFFF, 2'h0);
    rd(HI, 32'h3, 2'h0);
    chk("oe_16", pad_oe[16], 1'h0);
    wr(HI, 32'h1, 2'h0);
    chk("eint0", external_interrupt0, pad_in[16]);
    $display("high register test done");
    wr(32'hE002C008, 32'h0, 2'h2);
    rd(32'hE002C008, 32'h0, 2'h2);
    rd(LO, 32'hFFFFFFFF, 2'h0);
    $display("unmapped test done");
    close_out();
  end
endmodule
bind pfm_pin_mux pfm_pin_mux_sva i_pfm_pin_mux_sva (.*);
